// *** logic/bldcc_pkg.sv ***
// package: constants and types of the hall commutation block
package bldcc_pkg;

  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int DEAD_NS = 500;
  // least time, so round up
  localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int DEAD_W = 8;
  localparam int DEB_US = 10;
  localparam int DEB_CYC = DEB_US * CLK_MHZ;
  localparam int DEB_W = 11;

  // --------------------------------------------------------------
  // register map (word index on the plain port)
  // --------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int ADC_W = 10;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam logic [3:0] REG_MASK = 4'h2;
  localparam logic [3:0] REG_UV = 4'h3;
  localparam logic [3:0] REG_OT = 4'h4;
  localparam logic [3:0] REG_STATE = 4'h5;

  localparam int CTRL_RUN = 0;
  localparam int EV_HALL = 0;
  localparam int EV_HFLT = 1;
  localparam int EV_OC = 2;
  localparam int EV_UV = 3;
  localparam int EV_OT = 4;
  localparam int EV_N = 5;

  localparam logic [ADC_W-1:0] UV_RST = 10'h200;
  localparam logic [ADC_W-1:0] OT_RST = 10'h3ff;
  localparam logic [EV_N-1:0] MASK_RST = 5'h00;
  localparam logic CTRL_RST = 1'b0;

  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef enum logic [1:0] {LVL_WEAK, LVL_MID, LVL_STRONG} bldcc_level_t;

  // bit 2 = phase u, 1 = v, 0 = w
  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } bldcc_gate_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bldcc_bus_t;

endpackage

// *** logic/bldcc_deadtime.sv ***
// module: one half bridge with dead time between its two switches
`timescale 1ns/100ps
module bldcc_deadtime (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_req_high,
  input wire logic i_req_low,
  output logic o_high,
  output logic o_low
);
  logic [bldcc_pkg::DEAD_W-1:0] cnt_reg;
  logic [bldcc_pkg::DEAD_W-1:0] since_high_reg;

  // switch-off is immediate, switch-on waits out the gap
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_high <= 1'b0;
      o_low <= 1'b0;
      cnt_reg <= '0;
    end else if ((o_high & ~i_req_high) | (o_low & ~i_req_low)) begin
      o_high <= 1'b0;
      o_low <= 1'b0;
      cnt_reg <= bldcc_pkg::DEAD_W'(bldcc_pkg::DEAD_CYC);
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end else begin
      o_high <= i_req_high & ~i_req_low;
      o_low <= i_req_low & ~i_req_high;
    end
  end

  // helper: cycles since the high switch was last on
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      since_high_reg <= '1;
    end else if (o_high) begin
      since_high_reg <= '0;
    end else if (since_high_reg != '1) begin
      since_high_reg <= since_high_reg + 1'b1;
    end
  end

  a_dead_gap: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $rose(o_low) |-> since_high_reg >= bldcc_pkg::DEAD_CYC)
    else $error("low switch on inside dead time");
  a_no_shoot: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !(o_high && o_low))
    else $error("both switches of a phase on");
endmodule

// *** logic/bldcc_button.sv ***
// module: push button synchroniser, debounce and press pulse
`timescale 1ns/100ps
module bldcc_button (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_pin,
  output logic o_press
);
  logic meta_reg;
  logic sync_reg;
  logic stable_reg;
  logic [bldcc_pkg::DEB_W-1:0] cnt_reg;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= i_pin;
      sync_reg <= meta_reg;
    end
  end

  // contact bounce shorter than the window is ignored
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stable_reg <= 1'b0;
      cnt_reg <= '0;
      o_press <= 1'b0;
    end else begin
      o_press <= 1'b0;
      if (sync_reg == stable_reg) begin
        cnt_reg <= '0;
      end else if (cnt_reg == bldcc_pkg::DEB_W'(bldcc_pkg::DEB_CYC - 1)) begin
        cnt_reg <= '0;
        stable_reg <= sync_reg;
        o_press <= sync_reg;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
endmodule

// *** logic/bldcc_ctrl.sv ***
// module: hall commutation controller top with lamps, faults, registers
`timescale 1ns/100ps
module bldcc_ctrl (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire bldcc_pkg::bldcc_bus_t i_bus,
  output logic [bldcc_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_hall_u,
  input wire logic i_hall_v,
  input wire logic i_hall_w,
  input wire logic i_level_button,
  input wire logic i_lamp_button,
  input wire logic i_direction_switch,
  input wire logic i_overcurrent_cmp,
  input wire logic [bldcc_pkg::ADC_W-1:0] i_batt_sample,
  input wire logic i_batt_valid,
  input wire logic [bldcc_pkg::ADC_W-1:0] i_temp_sample,
  input wire logic i_temp_valid,
  output logic o_high_u_gate,
  output logic o_high_v_gate,
  output logic o_high_w_gate,
  output logic o_low_u_gate,
  output logic o_low_v_gate,
  output logic o_low_w_gate,
  output logic [2:0] o_level_lamps,
  output logic o_fault_lamp,
  output logic o_work_lamp,
  output logic o_irq
);

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);

  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  logic [4:0] meta_reg;
  logic [4:0] sync_reg;
  logic [2:0] hall_s;
  logic dir_s;
  logic oc_s;

  // every flop here is cleared by the supervisor reset
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= {i_hall_u, i_hall_v, i_hall_w, i_direction_switch,
                   i_overcurrent_cmp};
      sync_reg <= meta_reg;
    end
  end

  assign hall_s = sync_reg[4:2];
  assign dir_s = sync_reg[1];
  assign oc_s = sync_reg[0];

  // --------------------------------------------------------------
  // buttons
  // --------------------------------------------------------------
  logic level_press;
  logic lamp_press;

  bldcc_button u_level_btn (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_pin(i_level_button),
    .o_press(level_press)
  );

  bldcc_button u_lamp_btn (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_pin(i_lamp_button),
    .o_press(lamp_press)
  );

  bldcc_pkg::bldcc_level_t level_reg;
  bldcc_pkg::bldcc_level_t level_next;

  always_comb begin
    case (level_reg)
      bldcc_pkg::LVL_WEAK: level_next = bldcc_pkg::LVL_MID;
      bldcc_pkg::LVL_MID: level_next = bldcc_pkg::LVL_STRONG;
      default: level_next = bldcc_pkg::LVL_WEAK;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      level_reg <= bldcc_pkg::LVL_WEAK;
    end else if (level_press) begin
      level_reg <= level_next;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_work_lamp <= 1'b0;
    end else if (lamp_press) begin
      o_work_lamp <= ~o_work_lamp;
    end
  end

  // thermometer style: weak one lamp, strong all three
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_level_lamps <= 3'h1;
    end else begin
      case (level_reg)
        bldcc_pkg::LVL_WEAK: o_level_lamps <= 3'h1;
        bldcc_pkg::LVL_MID: o_level_lamps <= 3'h3;
        default: o_level_lamps <= 3'h7;
      endcase
    end
  end

  // --------------------------------------------------------------
  // commutation
  // --------------------------------------------------------------
  function automatic bldcc_pkg::bldcc_gate_t cw_map(input logic [2:0] h);
    bldcc_pkg::bldcc_gate_t g;
    g = '0;
    case (h)
      3'h1: g = '{high: 3'h4, low: 3'h1};
      3'h3: g = '{high: 3'h4, low: 3'h2};
      3'h7: g = '{high: 3'h1, low: 3'h2};
      3'h6: g = '{high: 3'h1, low: 3'h4};
      3'h4: g = '{high: 3'h2, low: 3'h4};
      3'h0: g = '{high: 3'h2, low: 3'h1};
      default: g = '0;
    endcase
    return g;
  endfunction

  logic [2:0] hall_prev_reg;
  logic dir_prev_reg;
  logic seen_reg;
  logic hall_chg;
  logic hall_bad;
  bldcc_pkg::bldcc_gate_t cw_gate;
  bldcc_pkg::bldcc_gate_t comm_reg;
  bldcc_pkg::bldcc_gate_t req;

  assign hall_chg = seen_reg && (hall_s != hall_prev_reg);
  assign hall_bad = (hall_s == 3'h2) || (hall_s == 3'h5);
  assign cw_gate = cw_map(hall_s);

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hall_prev_reg <= '0;
      dir_prev_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else begin
      hall_prev_reg <= hall_s;
      dir_prev_reg <= dir_s;
      seen_reg <= 1'b1;
    end
  end

  // reversing the current in every step walks the sequence backwards
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      comm_reg <= '0;
    end else if (!seen_reg || hall_chg || dir_s != dir_prev_reg) begin
      if (dir_s) begin
        comm_reg <= '{high: cw_gate.low, low: cw_gate.high};
      end else begin
        comm_reg <= cw_gate;
      end
    end
  end

  // --------------------------------------------------------------
  // faults
  // --------------------------------------------------------------
  logic [bldcc_pkg::ADC_W-1:0] uv_thr_reg;
  logic [bldcc_pkg::ADC_W-1:0] ot_thr_reg;
  logic uv_reg;
  logic ot_reg;
  logic run_reg;
  logic fault_any;
  logic kill;

  // conditions hold between samples until a fresh sample clears them
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      uv_reg <= 1'b0;
    end else if (i_batt_valid) begin
      uv_reg <= i_batt_sample < uv_thr_reg;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ot_reg <= 1'b0;
    end else if (i_temp_valid) begin
      ot_reg <= i_temp_sample > ot_thr_reg;
    end
  end

  assign fault_any = oc_s || uv_reg || ot_reg || hall_bad;
  assign kill = !run_reg || fault_any;
  assign req = kill ? '0 : comm_reg;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_fault_lamp <= 1'b0;
    end else begin
      o_fault_lamp <= fault_any;
    end
  end

  // --------------------------------------------------------------
  // gate drivers
  // --------------------------------------------------------------
  logic [2:0] gate_high;
  logic [2:0] gate_low;

  for (genvar p = 0; p < 3; p++) begin : g_phase
    bldcc_deadtime u_dt (
      .i_mclk(i_mclk),
      .i_reset_n(i_reset_n),
      .i_req_high(req.high[p]),
      .i_req_low(req.low[p]),
      .o_high(gate_high[p]),
      .o_low(gate_low[p])
    );
  end

  assign {o_high_u_gate, o_high_v_gate, o_high_w_gate} = gate_high;
  assign {o_low_u_gate, o_low_v_gate, o_low_w_gate} = gate_low;

  // --------------------------------------------------------------
  // registers and interrupt
  // --------------------------------------------------------------
  logic [bldcc_pkg::EV_N-1:0] stat_reg;
  logic [bldcc_pkg::EV_N-1:0] mask_reg;
  logic [bldcc_pkg::EV_N-1:0] ev;
  logic [bldcc_pkg::EV_N-1:0] stat_clr;
  logic wr_stat;

  assign ev[bldcc_pkg::EV_HALL] = hall_chg;
  assign ev[bldcc_pkg::EV_HFLT] = hall_bad;
  assign ev[bldcc_pkg::EV_OC] = oc_s;
  assign ev[bldcc_pkg::EV_UV] = uv_reg;
  assign ev[bldcc_pkg::EV_OT] = ot_reg;

  assign wr_stat = i_bus.wr && (i_bus.addr == bldcc_pkg::REG_STAT);
  assign stat_clr = wr_stat ? i_bus.wdata[bldcc_pkg::EV_N-1:0] : '0;

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= (stat_reg & ~stat_clr) | ev;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      run_reg <= bldcc_pkg::CTRL_RST;
      mask_reg <= bldcc_pkg::MASK_RST;
      uv_thr_reg <= bldcc_pkg::UV_RST;
      ot_thr_reg <= bldcc_pkg::OT_RST;
    end else if (i_bus.wr) begin
      case (i_bus.addr)
        bldcc_pkg::REG_CTRL: run_reg <= i_bus.wdata[bldcc_pkg::CTRL_RUN];
        bldcc_pkg::REG_MASK: mask_reg <= i_bus.wdata[bldcc_pkg::EV_N-1:0];
        bldcc_pkg::REG_UV: uv_thr_reg <= i_bus.wdata[bldcc_pkg::ADC_W-1:0];
        bldcc_pkg::REG_OT: ot_thr_reg <= i_bus.wdata[bldcc_pkg::ADC_W-1:0];
        default: ;
      endcase
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= '0;
    end else if (i_bus.rd) begin
      case (i_bus.addr)
        bldcc_pkg::REG_CTRL: o_rdata <= {15'h0000, run_reg};
        bldcc_pkg::REG_STAT: o_rdata <= {11'h000, stat_reg};
        bldcc_pkg::REG_MASK: o_rdata <= {11'h000, mask_reg};
        bldcc_pkg::REG_UV: o_rdata <= {6'h00, uv_thr_reg};
        bldcc_pkg::REG_OT: o_rdata <= {6'h00, ot_thr_reg};
        bldcc_pkg::REG_STATE: o_rdata <= {4'h0, hall_s, dir_s,
          o_work_lamp, level_reg, oc_s, uv_reg, ot_reg, hall_bad, kill};
        default: o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  assign o_irq = |(stat_reg & mask_reg);

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  sequence s_cw_step(logic [2:0] code);
    hall_chg && !dir_s && dir_prev_reg == dir_s && hall_s == code;
  endsequence

  sequence s_fault_held;
    fault_any ##1 fault_any;
  endsequence

  a_map_cw_one: assert property (s_cw_step(3'h1) |=>
    comm_reg == bldcc_pkg::bldcc_gate_t'{high: 3'h4, low: 3'h1})
    else $error("hall 001 mapped wrongly");
  a_map_cw_six: assert property (s_cw_step(3'h6) |=>
    comm_reg == bldcc_pkg::bldcc_gate_t'{high: 3'h1, low: 3'h4})
    else $error("hall 110 mapped wrongly");
  a_bad_code_off: assert property (hall_bad ##1 hall_bad |->
    gate_high == 3'h0 && gate_low == 3'h0 && o_fault_lamp)
    else $error("gates on with invalid hall code");
  a_hall_event: assert property (hall_chg |=>
    stat_reg[bldcc_pkg::EV_HALL])
    else $error("hall change not flagged");
  // presses are single pulses far apart, so check each step on its own
  a_level_step: assert property (level_press |=> level_reg ==
    (($past(level_reg) == bldcc_pkg::LVL_WEAK) ? bldcc_pkg::LVL_MID :
     ($past(level_reg) == bldcc_pkg::LVL_MID) ? bldcc_pkg::LVL_STRONG :
     bldcc_pkg::LVL_WEAK))
    else $error("level does not cycle through three");
  a_lamp_toggle: assert property (lamp_press |=>
    o_work_lamp != $past(o_work_lamp))
    else $error("work lamp not toggled");
  a_level_lamps: assert property (##1 o_level_lamps ==
    (($past(level_reg) == bldcc_pkg::LVL_WEAK) ? 3'h1 :
     ($past(level_reg) == bldcc_pkg::LVL_MID) ? 3'h3 : 3'h7))
    else $error("level lamps disagree with level");
  a_fault_lamp: assert property (s_fault_held |-> o_fault_lamp)
    else $error("fault lamp dark during fault");
  a_ccw_swap: assert property (hall_chg && dir_s && dir_prev_reg |=>
    comm_reg.high == $past(cw_gate.low))
    else $error("reverse sequence wrong");
  a_oc_kill: assert property (oc_s ##1 oc_s |->
    gate_high == 3'h0 && gate_low == 3'h0)
    else $error("gates on during over-current");
  a_uv_flag: assert property (i_batt_valid && i_batt_sample < uv_thr_reg
    |=> uv_reg)
    else $error("undervoltage not flagged");
  a_uv_kill: assert property (uv_reg ##1 uv_reg |->
    gate_high == 3'h0 && gate_low == 3'h0)
    else $error("gates on during undervoltage");

endmodule

// *** sim/bldcc_bridge_model.sv ***
// partner: three half bridges that count gate overlap and short dead time
`timescale 1ns/100ps
module bldcc_bridge_model (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire bldcc_pkg::bldcc_gate_t i_gate,
  output logic [7:0] o_viol
);
  // --------------------------------------------------------------
  // off-time counters, one pair a phase
  // --------------------------------------------------------------
  logic [7:0] hi_off [3];
  logic [7:0] lo_off [3];
  bldcc_pkg::bldcc_gate_t prev;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_viol <= 8'h00;
      prev <= '0;
      for (int p = 0; p < 3; p++) begin
        hi_off[p] <= 8'hff;
        lo_off[p] <= 8'hff;
      end
    end else begin
      prev <= i_gate;
      for (int p = 0; p < 3; p++) begin
        hi_off[p] <= i_gate.high[p] ? 8'h00 :
                     (hi_off[p] == 8'hff ? 8'hff : hi_off[p] + 8'h01);
        lo_off[p] <= i_gate.low[p] ? 8'h00 :
                     (lo_off[p] == 8'hff ? 8'hff : lo_off[p] + 8'h01);
        // one cycle of slack for where the count starts
        if ((i_gate.high[p] && i_gate.low[p]) ||
            (i_gate.low[p] && !prev.low[p] &&
             hi_off[p] < bldcc_pkg::DEAD_CYC - 1) ||
            (i_gate.high[p] && !prev.high[p] &&
             lo_off[p] < bldcc_pkg::DEAD_CYC - 1)) begin
          o_viol <= o_viol + 8'h01;
        end
      end
    end
  end
endmodule

// *** sim/bldcc_ctrl_tb.sv ***
// testbench: commutation, faults, buttons, lamps, irq and registers
`timescale 1ns/100ps
module bldcc_ctrl_tb;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  bldcc_pkg::bldcc_bus_t bus = '0;
  logic [15:0] rdata;
  logic [2:0] hall = 3'h1;
  logic lvl_btn = 1'b0;
  logic lamp_btn = 1'b0;
  logic dir = 1'b0;
  logic oc = 1'b0;
  logic [9:0] batt = 10'h3ff;
  logic bv = 1'b0;
  logic [9:0] temp = 10'h000;
  logic tv = 1'b0;
  wire bldcc_pkg::bldcc_gate_t gate;
  logic [2:0] lamps;
  logic fault;
  logic work;
  logic irq;
  logic [7:0] viol;
  logic [15:0] d;
  logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h7, 3'h6, 3'h4, 3'h0};
  logic [2:0] lv [4] = '{3'h3, 3'h7, 3'h1, 3'h3};
  int fails = 0;
  int n_checks = 0;

  always #5 i_mclk = ~i_mclk;

  bldcc_ctrl dut_u (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_bus(bus), .o_rdata(rdata),
    .i_hall_u(hall[2]), .i_hall_v(hall[1]), .i_hall_w(hall[0]),
    .i_level_button(lvl_btn), .i_lamp_button(lamp_btn),
    .i_direction_switch(dir), .i_overcurrent_cmp(oc),
    .i_batt_sample(batt), .i_batt_valid(bv),
    .i_temp_sample(temp), .i_temp_valid(tv),
    .o_high_u_gate(gate.high[2]), .o_high_v_gate(gate.high[1]),
    .o_high_w_gate(gate.high[0]), .o_low_u_gate(gate.low[2]),
    .o_low_v_gate(gate.low[1]), .o_low_w_gate(gate.low[0]),
    .o_level_lamps(lamps), .o_fault_lamp(fault), .o_work_lamp(work),
    .o_irq(irq)
  );

  bldcc_bridge_model br_u (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_gate(gate), .o_viol(viol)
  );

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_gate(input bldcc_pkg::bldcc_gate_t exp);
    chk({10'h000, gate}, {10'h000, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    bus.wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask

  function automatic bldcc_pkg::bldcc_gate_t exp_g(input logic [2:0] h,
      input logic ccw);
    bldcc_pkg::bldcc_gate_t g;
    case (h)
      3'h1: g = {3'h4, 3'h1};
      3'h3: g = {3'h4, 3'h2};
      3'h7: g = {3'h1, 3'h2};
      3'h6: g = {3'h1, 3'h4};
      3'h4: g = {3'h2, 3'h4};
      3'h0: g = {3'h2, 3'h1};
      default: g = '0;
    endcase
    if (ccw) g = {g.low, g.high};
    return g;
  endfunction

  // long wait covers sync, update and a full dead time
  task automatic hstep(input logic [2:0] h, input logic ccw);
    @(posedge i_mclk);
    hall <= h;
    dir <= ccw;
    cyc(80);
    chk_gate(exp_g(h, ccw));
  endtask

  task automatic adc(input logic t, input logic [9:0] v);
    @(posedge i_mclk);
    {tv, bv} <= {t, !t};
    if (t) temp <= v;
    else batt <= v;
    @(posedge i_mclk);
    {tv, bv} <= 2'b00;
    cyc(5);
  endtask

  task automatic press(input logic lamp);
    @(posedge i_mclk);
    {lamp_btn, lvl_btn} <= {lamp, !lamp};
    cyc(1100);
    {lamp_btn, lvl_btn} <= 2'b00;
    cyc(1100);
  endtask

  task automatic faulted(input int b);
    chk_gate('0);
    chk(16'(fault), 16'h0001);
    rd(bldcc_pkg::REG_STAT, d);
    chk(d & (16'h0001 << b), 16'h0001 << b);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial begin
    repeat (12) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    cyc(2);
    chk_gate('0);
    chk({13'h0000, lamps}, 16'h0001);
    chk({13'h0000, fault, work, irq}, 16'h0000);
    rd(bldcc_pkg::REG_UV, d);
    chk(d, 16'h0200);
    rd(bldcc_pkg::REG_OT, d);
    chk(d, 16'h03ff);
    wr(4'hf, 16'hffff);
    rd(4'hf, d);
    chk(d, 16'h0000);
    $display("done: reset");
    wr(bldcc_pkg::REG_MASK, 16'h0004);
    wr(bldcc_pkg::REG_CTRL, 16'h0001);
    for (int k = 0; k < 12; k++) begin
      hstep(k < 6 ? seq[k] : seq[11 - k], k >= 6);
    end
    rd(bldcc_pkg::REG_STAT, d);
    chk(d & 16'h0001, 16'h0001);
    chk(16'(irq), 16'h0000);
    hstep(3'h2, 1'b0);
    faulted(bldcc_pkg::EV_HFLT);
    hstep(3'h5, 1'b0);
    faulted(bldcc_pkg::EV_HFLT);
    hstep(3'h1, 1'b0);
    rd(bldcc_pkg::REG_STATE, d);
    chk(d, 16'h0200);
    $display("done: commutation");
    @(posedge i_mclk);
    oc <= 1'b1;
    cyc(10);
    faulted(bldcc_pkg::EV_OC);
    chk(16'(irq), 16'h0001);
    @(posedge i_mclk);
    oc <= 1'b0;
    cyc(10);
    wr(bldcc_pkg::REG_STAT, 16'h001f);
    cyc(2);
    chk(16'(irq), 16'h0000);
    cyc(80);
    chk_gate(exp_g(3'h1, 1'b0));
    wr(bldcc_pkg::REG_UV, 16'h0100);
    adc(1'b0, 10'h0ff);
    faulted(bldcc_pkg::EV_UV);
    adc(1'b0, 10'h100);
    cyc(80);
    chk_gate(exp_g(3'h1, 1'b0));
    wr(bldcc_pkg::REG_OT, 16'h0100);
    adc(1'b1, 10'h101);
    faulted(bldcc_pkg::EV_OT);
    adc(1'b1, 10'h100);
    chk(16'(fault), 16'h0000);
    $display("done: faults");
    for (int k = 0; k < 4; k++) begin
      press(1'b0);
      chk({13'h0000, lamps}, {13'h0000, lv[k]});
    end
    press(1'b1);
    chk(16'(work), 16'h0001);
    $display("done: buttons");
    @(posedge i_mclk);
    i_reset_n <= 1'b0;
    cyc(2);
    chk({gate, 1'b0, lamps, fault, work, irq}, 16'h0008);
    @(posedge i_mclk);
    i_reset_n <= 1'b1;
    cyc(80);
    chk_gate('0);
    chk({8'h00, viol}, 16'h0000);
    $display("done: mid-run reset");
    end_sim();
  end

  initial begin
    repeat (60000) @(posedge i_mclk);
    fails++;
    end_sim();
  end
endmodule
